// file: src/gts_top.sv
// Open transition transfer sequencer between main line and standby generator line
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "gts_regs.svh"

module gts_top import gts_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire gts_line_t MAIN_LINE_I,
	input wire gts_line_t STANDBY_LINE_I,
	input wire gts_panel_t PANEL_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WE_I,
	input wire logic RE_I,
	output logic [31:0] RDATA_O,
	output gts_cmd_t CMD_O,
	output logic IRQ_O
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	gts_line_t main_m, main_s, stby_m, stby_s;
	gts_panel_t pan_m, pan_s;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			main_m <= '0;
			main_s <= '0;
			stby_m <= '0;
			stby_s <= '0;
			pan_m <= '0;
			pan_s <= '0;
		end else begin
			main_m <= MAIN_LINE_I;
			main_s <= main_m;
			stby_m <= STANDBY_LINE_I;
			stby_s <= stby_m;
			pan_m <= PANEL_I;
			pan_s <= pan_m;
		end
	end

	function automatic logic line_bad(input gts_line_t l);
		return l.over_v | l.under_v | l.over_f | l.under_f;
	endfunction

	logic main_bad, stby_bad;
	assign main_bad = line_bad(main_s);
	assign stby_bad = line_bad(stby_s);

	// ****************************************
	// Register file
	// ****************************************
	logic [`DLY_W-1:0] dly [0:`DLY_N-1];
	logic [`DLY_W-1:0] next_dly [0:`DLY_N-1];
	logic [`IRQ_W-1:0] irq_st, next_irq_st, irq_en, next_irq_en, events;
	logic [31:0] next_rdata, status_word;
	gts_state_t st, next_st;
	logic main_cl, stby_cl, gen_on, alarm;

	assign status_word = {20'h00000, st, main_bad, stby_bad, main_cl, stby_cl, gen_on, alarm, pan_s.auto_sel,
		pan_s.ret_en};

	always_comb begin
		next_dly = dly;
		next_irq_en = irq_en;
		next_irq_st = irq_st;
		next_rdata = 32'h00000000;
		if (WE_I) begin
			if ((ADDR_I < `OFF_STATUS) && (ADDR_I[1:0] == 2'h0)) begin
				next_dly[ADDR_I[4:2]] = WDATA_I[`DLY_W-1:0];
			end
			if (ADDR_I == `OFF_IRQ_CLR) begin
				next_irq_st = irq_st & ~WDATA_I[`IRQ_W-1:0];
			end
			if (ADDR_I == `OFF_IRQ_EN) begin
				next_irq_en = WDATA_I[`IRQ_W-1:0];
			end
		end
		// Set wins over clear
		next_irq_st = next_irq_st | events;
		if (RE_I) begin
			unique case (ADDR_I)
				`OFF_GO_DLY: next_rdata = {24'h000000, dly[`DLY_GO]};
				`OFF_SC_DLY: next_rdata = {24'h000000, dly[`DLY_SC]};
				`OFF_SO_DLY: next_rdata = {24'h000000, dly[`DLY_SO]};
				`OFF_MC_DLY: next_rdata = {24'h000000, dly[`DLY_MC]};
				`OFF_GS_DLY: next_rdata = {24'h000000, dly[`DLY_GS]};
				`OFF_AL_DLY: next_rdata = {24'h000000, dly[`DLY_AL]};
				`OFF_STATUS: next_rdata = status_word;
				`OFF_IRQ_ST: next_rdata = {27'h0000000, irq_st};
				`OFF_IRQ_EN: next_rdata = {27'h0000000, irq_en};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < `DLY_N; i++) begin
				dly[i] <= `DLY_RST;
			end
			irq_st <= '0;
			irq_en <= '0;
			RDATA_O <= 32'h00000000;
		end else begin
			dly <= next_dly;
			irq_st <= next_irq_st;
			irq_en <= next_irq_en;
			RDATA_O <= next_rdata;
		end
	end

	assign IRQ_O = |(irq_st & irq_en);

	// ****************************************
	// Sequence timer
	// ****************************************
	logic [`PRE_W-1:0] pre, next_pre;
	logic [`DLY_W-1:0] sec, next_sec, cur_dly;
	logic tick, done;

	assign tick = (pre == `PRE_W'(TICK_CYCLES - 1));

	always_comb begin
		unique case (st)
			ST_START_WAIT: cur_dly = dly[`DLY_GO];
			ST_CLOSE_WAIT: cur_dly = dly[`DLY_SC];
			ST_RET_OPEN_WAIT: cur_dly = dly[`DLY_SO];
			ST_MAIN_CLOSE_WAIT: cur_dly = dly[`DLY_MC];
			ST_GEN_STOP_WAIT: cur_dly = dly[`DLY_GS];
			default: cur_dly = `DLY_RST;
		endcase
	end

	assign done = (sec >= cur_dly);

	// ****************************************
	// Transfer state machine
	// ****************************************
	logic next_main_cl, next_stby_cl, next_gen_on;
	logic [`IRQ_W-1:0] seq_ev;

	always_comb begin
		next_st = st;
		next_main_cl = main_cl;
		next_stby_cl = stby_cl;
		next_gen_on = gen_on;
		seq_ev = '0;
		unique case (st)
			ST_NORMAL: begin
				next_gen_on = 1'b0;
				next_stby_cl = 1'b0;
				next_main_cl = !stby_cl;
				if (main_bad) begin
					next_st = ST_START_WAIT;
					seq_ev[`IRQ_FAULT] = 1'b1;
				end
			end
			ST_START_WAIT, ST_GEN_WAIT: begin
				if (!main_bad) begin
					next_st = ST_NORMAL;
					next_gen_on = 1'b0;
					seq_ev[`IRQ_ABORT] = 1'b1;
				end else if (st == ST_START_WAIT) begin
					if (done) begin
						next_gen_on = 1'b1;
						next_st = ST_GEN_WAIT;
					end
				end else if (!stby_bad) begin
					next_main_cl = 1'b0;
					next_st = ST_CLOSE_WAIT;
				end
			end
			ST_CLOSE_WAIT: begin
				if (stby_bad) begin
					next_st = ST_GEN_WAIT;
				end else if (done) begin
					next_stby_cl = 1'b1;
					next_st = ST_ON_STANDBY;
					seq_ev[`IRQ_XFER] = 1'b1;
				end
			end
			ST_ON_STANDBY: begin
				if (pan_s.ret_en && !main_bad) begin
					next_st = ST_RET_OPEN_WAIT;
				end
			end
			ST_RET_OPEN_WAIT: begin
				if (main_bad) begin
					next_st = ST_ON_STANDBY;
				end else if (done) begin
					next_stby_cl = 1'b0;
					next_st = ST_MAIN_CLOSE_WAIT;
				end
			end
			ST_MAIN_CLOSE_WAIT: begin
				if (main_bad) begin
					next_st = ST_START_WAIT;
				end else if (done) begin
					next_main_cl = 1'b1;
					next_st = ST_GEN_STOP_WAIT;
				end
			end
			ST_GEN_STOP_WAIT: begin
				if (done) begin
					next_gen_on = 1'b0;
					next_st = ST_NORMAL;
					seq_ev[`IRQ_RETURN] = 1'b1;
				end
			end
			ST_MANUAL: begin
				if (pan_s.man_sel == `SEL_MAIN) begin
					next_gen_on = 1'b0;
					next_stby_cl = 1'b0;
					next_main_cl = !stby_cl;
				end else if (pan_s.man_sel == `SEL_GEN) begin
					next_gen_on = 1'b1;
					next_main_cl = 1'b0;
					next_stby_cl = !main_cl;
				end else begin
					next_gen_on = 1'b0;
					next_main_cl = 1'b0;
					next_stby_cl = 1'b0;
				end
				if (pan_s.auto_sel) begin
					next_st = ST_NORMAL;
				end
			end
			default: next_st = ST_NORMAL;
		endcase
		if (!pan_s.auto_sel) begin
			next_st = ST_MANUAL;
		end
		if (next_st != st) begin
			next_pre = '0;
			next_sec = '0;
		end else if (tick) begin
			next_pre = '0;
			next_sec = (sec == {`DLY_W{1'b1}}) ? sec : sec + `DLY_W'(1);
		end else begin
			next_pre = pre + `PRE_W'(1);
			next_sec = sec;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st <= ST_NORMAL;
			main_cl <= 1'b0;
			stby_cl <= 1'b0;
			gen_on <= 1'b0;
			pre <= '0;
			sec <= '0;
		end else begin
			st <= next_st;
			main_cl <= next_main_cl;
			stby_cl <= next_stby_cl;
			gen_on <= next_gen_on;
			pre <= next_pre;
			sec <= next_sec;
		end
	end

	// ****************************************
	// Dual loss alarm
	// ****************************************
	logic [`PRE_W-1:0] al_pre, next_al_pre;
	logic [`DLY_W-1:0] al_sec, next_al_sec;
	logic both_bad, next_alarm;

	assign both_bad = main_bad && stby_bad;

	always_comb begin
		next_al_pre = '0;
		next_al_sec = '0;
		next_alarm = 1'b0;
		if (both_bad) begin
			next_alarm = (al_sec >= dly[`DLY_AL]);
			if (al_pre == `PRE_W'(TICK_CYCLES - 1)) begin
				next_al_sec = (al_sec == {`DLY_W{1'b1}}) ? al_sec : al_sec + `DLY_W'(1);
			end else begin
				next_al_pre = al_pre + `PRE_W'(1);
				next_al_sec = al_sec;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			al_pre <= '0;
			al_sec <= '0;
			alarm <= 1'b0;
		end else begin
			al_pre <= next_al_pre;
			al_sec <= next_al_sec;
			alarm <= next_alarm;
		end
	end

	assign events = seq_ev | {next_alarm && !alarm, {(`IRQ_W-1){1'b0}}};
	assign CMD_O = '{main_close: main_cl, standby_close: stby_cl, gen_start: gen_on, alarm: alarm};

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	break_make_a: assert property (!(main_cl && stby_cl))
		else $error("Both breakers closed");
	fault_detect_a: assert property (st == ST_NORMAL && pan_s.auto_sel && main_s.under_f |=> st == ST_START_WAIT)
		else $error("Frequency fault not acted on");
	gen_start_a: assert property ($rose(gen_on) && $past(pan_s.auto_sel) |-> $past(st) == ST_START_WAIT
		&& $past(sec) >= $past(dly[`DLY_GO]))
		else $error("Generator started early");
	no_return_a: assert property (st == ST_ON_STANDBY && !pan_s.ret_en && pan_s.auto_sel |=>
		st == ST_ON_STANDBY && stby_cl && gen_on)
		else $error("Left standby without return enabled");
	abort_seq_a: assert property (st == ST_GEN_WAIT && !main_bad && pan_s.auto_sel |=> !gen_on && st == ST_NORMAL)
		else $error("Sequence not aborted");
	close_hold_a: assert property (st == ST_CLOSE_WAIT && !done && !stby_bad && pan_s.auto_sel |=>
		st == ST_CLOSE_WAIT)
		else $error("Standby close abandoned");
	ret_abandon_a: assert property (st == ST_RET_OPEN_WAIT && main_bad && pan_s.auto_sel |=>
		st == ST_ON_STANDBY && stby_cl)
		else $error("Return not abandoned");
	start_rerun_a: assert property (st == ST_MAIN_CLOSE_WAIT && main_bad && pan_s.auto_sel |=>
		st == ST_START_WAIT && sec == 0 && pre == 0)
		else $error("Start delay not restarted");
	return_order_a: assert property ($rose(main_cl) && $past(st) == ST_MAIN_CLOSE_WAIT |-> !stby_cl
		&& $past(sec) >= $past(dly[`DLY_MC]))
		else $error("Main closed out of order");
	standby_open_a: assert property ($fell(stby_cl) && $past(st) == ST_RET_OPEN_WAIT |->
		$past(sec) >= $past(dly[`DLY_SO]))
		else $error("Standby opened early");
	gen_stop_a: assert property ($fell(gen_on) && $past(st) == ST_GEN_STOP_WAIT |-> main_cl
		&& $past(sec) >= $past(dly[`DLY_GS]))
		else $error("Generator stopped early");
	alarm_delay_a: assert property ($rose(alarm) |-> $past(both_bad) && $past(al_sec) >= $past(dly[`DLY_AL]))
		else $error("Alarm raised early");
	manual_main_a: assert property (st == ST_MANUAL && !pan_s.auto_sel && pan_s.man_sel == `SEL_MAIN
		&& !stby_cl |=> main_cl && !gen_on)
		else $error("Manual main selection ignored");
	manual_mode_a: assert property (!pan_s.auto_sel |=> st == ST_MANUAL)
		else $error("Manual mode not entered");
	sec_tick_a: assert property (next_st == st && tick && sec != 8'hFF |=> sec == $past(sec) + 8'h01)
		else $error("Second count lost");

endmodule // gts_top

// file: src/gts_regs.svh
// Register map, field positions and timing constants of the generator transfer sequencer
// Functional notes
// - Three modes: automatic with return, automatic without return, manual.
// - Over/under voltage and over/under frequency on either line count as faults.
// - Auto: main fault raises generator start after the generator start delay.
// - Standby healthy: open main breaker, close standby after standby close delay.
// - Auto without return: on main recovery stay on standby, generator running.
// - Auto with return: open standby, then close main after main close delay.
// - Standby opens after standby open delay, counted from main becoming healthy.
// - After main closes on return, generator stops after generator stop delay.
// - Both lines faulty: dual loss alarm after transfer alarm delay.
// - Manual: operator picks main source or generator source, no automatic switching.
// - Main healthy before standby healthy: abort sequence, drop generator start.
// - Main recovery during standby close delay still completes the transfer.
// - Main lost during standby open delay abandons the return transfer.
// - Main lost during main close delay restarts generator start delay.
`ifndef GTS_REGS_SVH
`define GTS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_GO_DLY 8'h00
`define OFF_SC_DLY 8'h04
`define OFF_SO_DLY 8'h08
`define OFF_MC_DLY 8'h0C
`define OFF_GS_DLY 8'h10
`define OFF_AL_DLY 8'h14
`define OFF_STATUS 8'h18
`define OFF_IRQ_ST 8'h1C
`define OFF_IRQ_CLR 8'h20
`define OFF_IRQ_EN 8'h24

// ****************************************
// Fields and reset values
// ****************************************
`define DLY_W 8
`define DLY_N 6
`define DLY_RST 8'h00
`define DLY_GO 3'h0
`define DLY_SC 3'h1
`define DLY_SO 3'h2
`define DLY_MC 3'h3
`define DLY_GS 3'h4
`define DLY_AL 3'h5
`define IRQ_W 5
`define IRQ_FAULT 0
`define IRQ_XFER 1
`define IRQ_RETURN 2
`define IRQ_ABORT 3
`define IRQ_ALARM 4
`define SEL_MAIN 2'h0
`define SEL_OFF 2'h1
`define SEL_GEN 2'h2

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 25000000
`define TICK_SECONDS 1
`define TICK_CYCLES (`CLK_HZ * `TICK_SECONDS)
`define PRE_W 25

`endif

// file: src/gts_pkg.sv
// Types shared by the generator transfer sequencer
package gts_pkg;
	typedef enum logic [3:0] {
		ST_NORMAL,
		ST_START_WAIT,
		ST_GEN_WAIT,
		ST_CLOSE_WAIT,
		ST_ON_STANDBY,
		ST_RET_OPEN_WAIT,
		ST_MAIN_CLOSE_WAIT,
		ST_GEN_STOP_WAIT,
		ST_MANUAL
	} gts_state_t;

	typedef struct packed {
		logic over_v;
		logic under_v;
		logic over_f;
		logic under_f;
	} gts_line_t;

	typedef struct packed {
		logic auto_sel;
		logic ret_en;
		logic [1:0] man_sel;
	} gts_panel_t;

	typedef struct packed {
		logic main_close;
		logic standby_close;
		logic gen_start;
		logic alarm;
	} gts_cmd_t;
endpackage

// file: testbench/gts_plant.sv
// Generator and standby line model facing the transfer sequencer
`timescale 1ns/1ns

module gts_plant import gts_pkg::*; #(
	parameter int unsigned GEN_UP = 8
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire gts_cmd_t cmd_i,
	input wire logic lost_i,
	output gts_line_t standby_o
);
	int unsigned run;

	// ****************************************
	// Generator run-up
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (RST_I || !cmd_i.gen_start) begin
			run <= 0;
		end else if (run < GEN_UP) begin
			run <= run + 1;
		end
	end

	// Low voltage and frequency until running, or when lost
	assign standby_o = (lost_i || run < GEN_UP) ? 4'h5 : 4'h0;
endmodule // gts_plant

// file: testbench/generator_transfer_sequencer_bench.sv
// Self-checking bench of the generator transfer sequencer
`timescale 1ns/1ns
`include "gts_regs.svh"

module generator_transfer_sequencer_bench import gts_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] main_line = 4'h0;
	logic [3:0] panel = 4'hC;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic lost = 1'b0;
	logic [31:0] rdata;
	logic [3:0] cmd;
	logic irq;
	gts_line_t standby;
	logic [31:0] d;
	int n;
	int miscompares = 0;
	int check_count = 0;

	gts_top #(.TICK_CYCLES(10)) u_dut (.CLK_I(clk), .RST_I(rst), .MAIN_LINE_I(main_line),
		.STANDBY_LINE_I(standby), .PANEL_I(panel), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we),
		.RE_I(re), .RDATA_O(rdata), .CMD_O(cmd), .IRQ_O(irq));
	gts_plant u_plant (.CLK_I(clk), .RST_I(rst), .cmd_i(cmd), .lost_i(lost), .standby_o(standby));

	initial begin
		forever #20 clk = ~clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic wait_cmd(input logic [3:0] mask, input logic [3:0] val, output int cnt);
		cnt = 0;
		while ((cmd & mask) !== val) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > 400) begin
				check(cnt, 0, "wait for command timed out");
				end_of_test();
			end
		end
	endtask

	task automatic in_range(input int v, input int lo, input int hi, input string msg);
		check(v >= lo && v <= hi, 1'b1, msg);
	endtask

	task automatic drive_main(input logic [3:0] v);
		@(posedge clk);
		main_line <= v;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs();
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), d);
			check(d, 32'h0, "delay reset value");
		end
		wr(`OFF_MC_DLY, 32'h1A5);
		rd(`OFF_MC_DLY, d);
		check(d, 32'hA5, "delay read back");
		rd(8'h80, d);
		check(d, 32'h0, "unmapped read");
		rd(`OFF_IRQ_CLR, d);
		check(d, 32'h0, "clear register read");
		rd(`OFF_STATUS, d);
		check(d, 32'h63, "status after reset");
		$display("test regs done");
	endtask

	task automatic test_faults_abort();
		wr(`OFF_GO_DLY, 32'h0);
		wr(`OFF_IRQ_CLR, 32'h1F);
		for (int i = 0; i < 4; i++) begin
			drive_main(4'(1 << i));
			wait_cmd(4'h2, 4'h2, n);
			drive_main(4'h0);
			wait_cmd(4'h2, 4'h0, n);
			in_range(n, 1, 7, "generator stop on abort");
			check(cmd[3:2], 2'b10, "breakers kept on abort");
			rd(`OFF_IRQ_ST, d);
			check(d[3], 1'b1, "abort event");
			wr(`OFF_IRQ_CLR, 32'h1F);
		end
		$display("test faults and abort done");
	endtask

	task automatic test_return();
		wr(`OFF_GO_DLY, 32'h2);
		wr(`OFF_SC_DLY, 32'h1);
		wr(`OFF_SO_DLY, 32'h1);
		wr(`OFF_MC_DLY, 32'h1);
		wr(`OFF_GS_DLY, 32'h1);
		drive_main(4'h8);
		wait_cmd(4'h2, 4'h2, n);
		in_range(n, 20, 26, "generator start delay");
		wait_cmd(4'h8, 4'h0, n);
		check(cmd[2], 1'b0, "standby still open");
		wait_cmd(4'hC, 4'h4, n);
		in_range(n, 10, 12, "standby close delay");
		drive_main(4'h0);
		wait_cmd(4'h4, 4'h0, n);
		in_range(n, 10, 14, "standby open delay");
		check(cmd[3], 1'b0, "main open before standby opens");
		wait_cmd(4'hC, 4'h8, n);
		in_range(n, 10, 12, "main close delay");
		check(cmd[1], 1'b1, "generator runs at main close");
		wait_cmd(4'h2, 4'h0, n);
		in_range(n, 10, 12, "generator stop delay");
		rd(`OFF_IRQ_ST, d);
		check(d[2:0], 3'b111, "transfer events");
		wr(`OFF_IRQ_CLR, 32'h1F);
		$display("test return transfer done");
	endtask

	task automatic test_special();
		wr(`OFF_GO_DLY, 32'h1);
		drive_main(4'h2);
		wait_cmd(4'h8, 4'h0, n);
		drive_main(4'h0);
		wait_cmd(4'hC, 4'h4, n);
		in_range(n, 9, 11, "transfer kept on main recovery");
		drive_main(4'h2);
		repeat (20) @(posedge clk);
		#1;
		check(cmd[3:1], 3'b011, "return abandoned on main loss");
		drive_main(4'h0);
		wait_cmd(4'h4, 4'h0, n);
		drive_main(4'h1);
		wait_cmd(4'hC, 4'h4, n);
		in_range(n, 24, 28, "start delay rerun on main loss");
		drive_main(4'h0);
		wait_cmd(4'h2, 4'h0, n);
		wr(`OFF_IRQ_CLR, 32'h1F);
		$display("test special cases done");
	endtask

	task automatic test_no_return();
		@(posedge clk);
		panel <= 4'h8;
		drive_main(4'h4);
		wait_cmd(4'hE, 4'h6, n);
		drive_main(4'h0);
		repeat (40) @(posedge clk);
		#1;
		check(cmd[3:1], 3'b011, "stay on standby");
		$display("test without return done");
	endtask

	task automatic test_manual();
		@(posedge clk);
		panel <= {2'b00, `SEL_MAIN};
		wait_cmd(4'hC, 4'h8, n);
		drive_main(4'h1);
		repeat (40) @(posedge clk);
		#1;
		check(cmd[3:2], 2'b10, "no automatic switching");
		@(posedge clk);
		panel <= {2'b00, `SEL_GEN};
		wait_cmd(4'hE, 4'h6, n);
		@(posedge clk);
		panel <= {2'b00, `SEL_OFF};
		wait_cmd(4'hE, 4'h0, n);
		in_range(n, 2, 4, "manual off opens both");
		drive_main(4'h0);
		panel <= {2'b00, `SEL_MAIN};
		wait_cmd(4'hC, 4'h8, n);
		@(posedge clk);
		panel <= 4'hC;
		$display("test manual done");
	endtask

	task automatic test_alarm();
		wr(`OFF_AL_DLY, 32'h1);
		wr(`OFF_IRQ_CLR, 32'h1F);
		wr(`OFF_IRQ_EN, 32'h10);
		check(irq, 1'b0, "interrupt idle before alarm");
		@(posedge clk);
		lost <= 1'b1;
		main_line <= 4'h2;
		wait_cmd(4'h1, 4'h1, n);
		in_range(n, 10, 14, "transfer alarm delay");
		check(irq, 1'b1, "alarm interrupt");
		wr(`OFF_IRQ_EN, 32'h0);
		check(irq, 1'b0, "interrupt masked");
		wr(`OFF_IRQ_CLR, 32'h1F);
		wr(`OFF_IRQ_EN, 32'h10);
		check(irq, 1'b0, "interrupt cleared");
		@(posedge clk);
		lost <= 1'b0;
		main_line <= 4'h0;
		wait_cmd(4'h1, 4'h0, n);
		in_range(n, 1, 5, "alarm release");
		$display("test alarm done");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		test_regs();
		test_faults_abort();
		test_return();
		test_special();
		test_no_return();
		test_manual();
		test_alarm();
		end_of_test();
	end
endmodule // generator_transfer_sequencer_bench
